// >>> hwd_pkg.sv
// Package for the haptic waveform memory decoder
package hwd_pkg;
	localparam int MEM_BYTES      = 100;
	localparam int ADDR_W         = 7;
	localparam logic [6:0] ADDR_SNIP_COUNT = 7'h00;
	localparam logic [6:0] ADDR_SEQ_COUNT  = 7'h01;
	localparam logic [6:0] ADDR_PTR_BASE   = 7'h02;
	localparam int MAX_SNIPPETS   = 15;
	localparam int MAX_SEQUENCES  = 16;
	localparam int RAMP_BIT       = 7;
	localparam int DUR_HI         = 6;
	localparam int DUR_LO         = 4;
	localparam int AMP_HI         = 3;
	localparam int AMP_LO         = 0;
	localparam logic [3:0] SILENCE_TB    = 4'h2;
	localparam logic signed [4:0] NEG_FULL = -5'sd7;
	localparam logic [4:0] SIGNED_MIN      = 5'h18;
	localparam int CLK_NS         = 10;
	localparam int TB0_US         = 5440;
	localparam int TB1_US         = 21760;
	localparam int TB2_US         = 43520;
	localparam int TB3_US         = 87040;
	localparam int TB_ALT0_US     = 1360;
	localparam int TB0_CYC        = TB0_US * 1000 / CLK_NS;
	localparam int TB1_CYC        = TB1_US * 1000 / CLK_NS;
	localparam int TB2_CYC        = TB2_US * 1000 / CLK_NS;
	localparam int TB3_CYC        = TB3_US * 1000 / CLK_NS;
	localparam int TB_ALT0_CYC    = TB_ALT0_US * 1000 / CLK_NS;

	typedef struct packed {
		logic             ramp_flag;
		logic [3:0]       hold_tb;
		logic signed [4:0] point_amplitude;
	} hwd_point_t;
endpackage

// >>> hwd_decoder.sv
// Waveform memory store and snippet point decoder
`timescale 1ns/1ps
`default_nettype none
module hwd_decoder #(
	parameter int TB0_CYCLES    = hwd_pkg::TB0_CYC,
	parameter int TB1_CYCLES    = hwd_pkg::TB1_CYC,
	parameter int TB2_CYCLES    = hwd_pkg::TB2_CYC,
	parameter int TB3_CYCLES    = hwd_pkg::TB3_CYC,
	parameter int TBA0_CYCLES   = hwd_pkg::TB_ALT0_CYC
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       srst,
	// Memory preload port
	input  wire logic                       mem_wr,
	input  wire logic [6:0]                 mem_addr,
	input  wire logic [7:0]                 mem_wdata,
	output logic      [7:0]                 mem_rdata,
	// Configuration
	input  wire logic                       accel_en,
	input  wire logic                       short_step_table_select,
	// Snippet play request
	input  wire logic                       play_start,
	input  wire logic [3:0]                 snippet_index,
	input  wire logic [1:0]                 timebase_code,
	input  wire logic                       seq_first,
	input  wire logic                       seq_looped,
	// Sequence lookup
	input  wire logic [3:0]                 seq_index,
	output logic      [6:0]                 seq_start_addr,
	output logic      [6:0]                 seq_end_addr,
	output logic                            seq_valid,
	// Header status
	output logic      [7:0]                 snippet_count,
	output logic      [7:0]                 sequence_count,
	// Playback status
	output logic                            busy,
	output logic                            point_strobe,
	output hwd_pkg::hwd_point_t             point_out,
	output logic                            snippet_done,
	output logic                            bad_index,
	output logic signed [9:0]               drive_level
);
	typedef enum {S_IDLE, S_FETCH, S_HOLD} hwd_state_t;

	logic [7:0] mem_ff [hwd_pkg::MEM_BYTES];
	hwd_state_t         state_ff;
	logic [6:0]         rd_addr_ff;
	logic [6:0]         end_addr_ff;
	logic               silence_ff;
	logic [31:0]        tb_cycles_ff;
	logic [31:0]        tb_cnt_ff;
	logic [3:0]         tb_left_ff;
	logic [3:0]         tb_total_ff;
	logic signed [9:0]  from_lvl_ff;
	logic signed [9:0]  to_lvl_ff;
	logic               ramp_ff;
	logic signed [9:0]  last_lvl_ff;

	logic [7:0]         cur_byte;
	logic signed [4:0]  nxt_amp;
	logic [31:0]        nxt_tb_cycles;
	logic [6:0]         snip_start;
	logic [6:0]         snip_end;
	logic [6:0]         seq_ptr_idx;
	logic               in_range;

	// Preload and read-back of the store
	always_ff @(posedge clock) begin
		if (mem_wr && mem_addr < 7'(hwd_pkg::MEM_BYTES)) begin
			mem_ff[mem_addr] <= mem_wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			mem_rdata <= 8'h00;
		end else if (mem_addr < 7'(hwd_pkg::MEM_BYTES)) begin
			mem_rdata <= mem_ff[mem_addr];
		end else begin
			mem_rdata <= 8'h00;
		end
	end

	// Header counts
	always_ff @(posedge clock) begin
		if (srst) begin
			snippet_count  <= 8'h00;
			sequence_count <= 8'h00;
		end else begin
			snippet_count  <= mem_ff[hwd_pkg::ADDR_SNIP_COUNT];
			sequence_count <= mem_ff[hwd_pkg::ADDR_SEQ_COUNT];
		end
	end

	// Snippet bounds: first snippet starts after pointer table, later after previous end
	always_comb begin
		if (snippet_index == 4'h1) begin
			snip_start = 7'(hwd_pkg::ADDR_PTR_BASE + 7'(snippet_count) + 7'(sequence_count));
		end else begin
			snip_start = mem_ff[7'(hwd_pkg::ADDR_PTR_BASE) + 7'(snippet_index) - 7'h2][6:0] + 7'h1;
		end
		snip_end = mem_ff[7'(hwd_pkg::ADDR_PTR_BASE) + 7'(snippet_index) - 7'h1][6:0];
	end

	// Sequence lookup, placed after snippet pointers
	always_comb begin
		seq_ptr_idx = 7'(hwd_pkg::ADDR_PTR_BASE) + 7'(snippet_count) + 7'(seq_index);
		in_range = (4'(seq_index) < 4'(hwd_pkg::MAX_SEQUENCES - 1) || seq_index == 4'hf)
			&& ({4'h0, seq_index} < sequence_count);
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			seq_start_addr <= 7'h00;
			seq_end_addr   <= 7'h00;
			seq_valid      <= 1'b0;
		end else begin
			seq_valid    <= in_range;
			seq_end_addr <= mem_ff[seq_ptr_idx][6:0];
			if (seq_index == 4'h0) begin
				seq_start_addr <= (snippet_count == 8'h00) ?
					7'(hwd_pkg::ADDR_PTR_BASE) + 7'(sequence_count) :
					mem_ff[seq_ptr_idx - 7'h1][6:0] + 7'h1;
			end else begin
				seq_start_addr <= mem_ff[seq_ptr_idx - 7'h1][6:0] + 7'h1;
			end
		end
	end

	// Timebase lookup
	always_comb begin
		case ({short_step_table_select, timebase_code})
			3'h0: nxt_tb_cycles = 32'(TB0_CYCLES);
			3'h1: nxt_tb_cycles = 32'(TB1_CYCLES);
			3'h2: nxt_tb_cycles = 32'(TB2_CYCLES);
			3'h3: nxt_tb_cycles = 32'(TB3_CYCLES);
			3'h4: nxt_tb_cycles = 32'(TBA0_CYCLES);
			3'h5: nxt_tb_cycles = 32'(TB0_CYCLES);
			3'h6: nxt_tb_cycles = 32'(TB1_CYCLES);
			default: nxt_tb_cycles = 32'(TB2_CYCLES);
		endcase
	end

	// Amplitude field decode
	always_comb begin
		cur_byte = mem_ff[rd_addr_ff];
		if (accel_en) begin
			nxt_amp = {1'b0, cur_byte[hwd_pkg::AMP_HI:hwd_pkg::AMP_LO]};
		end else if ({cur_byte[3], cur_byte[3:0]} == hwd_pkg::SIGNED_MIN) begin
			nxt_amp = hwd_pkg::NEG_FULL;
		end else begin
			nxt_amp = {cur_byte[3], cur_byte[3:0]};
		end
	end

	// Playback sequencing
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff     <= S_IDLE;
			rd_addr_ff   <= 7'h00;
			end_addr_ff  <= 7'h00;
			silence_ff   <= 1'b0;
			tb_cycles_ff <= 32'h0000_0001;
			tb_cnt_ff    <= 32'h0000_0000;
			tb_left_ff   <= 4'h0;
			tb_total_ff  <= 4'h1;
			from_lvl_ff  <= 10'sh000;
			to_lvl_ff    <= 10'sh000;
			ramp_ff      <= 1'b0;
			last_lvl_ff  <= 10'sh000;
			point_strobe <= 1'b0;
			point_out    <= '0;
			snippet_done <= 1'b0;
			bad_index    <= 1'b0;
		end else begin
			point_strobe <= 1'b0;
			snippet_done <= 1'b0;
			bad_index    <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					if (play_start) begin
						tb_cycles_ff <= nxt_tb_cycles;
						if (seq_first && !seq_looped) begin
							last_lvl_ff <= 10'sh000;
						end
						if (snippet_index == 4'h0) begin
							silence_ff <= 1'b1;
							state_ff   <= S_FETCH;
						end else if ({4'h0, snippet_index} > snippet_count) begin
							bad_index <= 1'b1;
						end else begin
							silence_ff  <= 1'b0;
							rd_addr_ff  <= snip_start;
							end_addr_ff <= snip_end;
							state_ff    <= S_FETCH;
						end
					end
				end
				S_FETCH: begin
					point_strobe <= 1'b1;
					tb_cnt_ff    <= 32'h0000_0000;
					from_lvl_ff  <= last_lvl_ff;
					if (silence_ff) begin
						point_out   <= '{ramp_flag: 1'b0, hold_tb: hwd_pkg::SILENCE_TB,
							point_amplitude: 5'sh00};
						tb_left_ff  <= hwd_pkg::SILENCE_TB;
						tb_total_ff <= hwd_pkg::SILENCE_TB;
						to_lvl_ff   <= 10'sh000;
						ramp_ff     <= 1'b0;
					end else begin
						point_out <= '{ramp_flag: cur_byte[hwd_pkg::RAMP_BIT],
							hold_tb: {1'b0, cur_byte[hwd_pkg::DUR_HI:hwd_pkg::DUR_LO]} + 4'h1,
							point_amplitude: nxt_amp};
						tb_left_ff  <= {1'b0, cur_byte[6:4]} + 4'h1;
						tb_total_ff <= {1'b0, cur_byte[6:4]} + 4'h1;
						to_lvl_ff   <= 10'(nxt_amp);
						ramp_ff     <= cur_byte[hwd_pkg::RAMP_BIT];
					end
					state_ff <= S_HOLD;
				end
				S_HOLD: begin
					if (tb_cnt_ff + 32'h1 >= tb_cycles_ff) begin
						tb_cnt_ff  <= 32'h0000_0000;
						tb_left_ff <= tb_left_ff - 4'h1;
						if (tb_left_ff == 4'h1) begin
							last_lvl_ff <= to_lvl_ff;
							if (silence_ff || rd_addr_ff >= end_addr_ff) begin
								snippet_done <= 1'b1;
								state_ff     <= S_IDLE;
							end else begin
								rd_addr_ff <= rd_addr_ff + 7'h1;
								state_ff   <= S_FETCH;
							end
						end
					end else begin
						tb_cnt_ff <= tb_cnt_ff + 32'h1;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// Output level: ramp in timebase steps, or hold the step value
	always_comb begin
		busy = (state_ff != S_IDLE);
		if (state_ff == S_HOLD && ramp_ff) begin
			drive_level = from_lvl_ff + 10'((to_lvl_ff - from_lvl_ff)
				* $signed({6'h00, tb_total_ff - tb_left_ff})
				/ $signed({6'h00, tb_total_ff}));
		end else if (state_ff == S_HOLD) begin
			drive_level = to_lvl_ff;
		end else begin
			drive_level = last_lvl_ff;
		end
	end

	silence_len_a: assert property (@(posedge clock) disable iff (srst)
		point_strobe && point_out.hold_tb == 4'h2 |-> tb_left_ff == 4'h2)
		else $error("hold count mismatch");
	hold_range_a: assert property (@(posedge clock) disable iff (srst)
		point_strobe |-> point_out.hold_tb >= 4'h1 && point_out.hold_tb <= 4'h8)
		else $error("hold out of range");
	amp_signed_a: assert property (@(posedge clock) disable iff (srst)
		point_strobe && !$past(accel_en) |-> point_out.point_amplitude != -5'sd8)
		else $error("minus eight passed");
	amp_unsigned_a: assert property (@(posedge clock) disable iff (srst)
		point_strobe && $past(accel_en) |-> !point_out.point_amplitude[4])
		else $error("unsigned amplitude negative");
	step_hold_a: assert property (@(posedge clock) disable iff (srst)
		state_ff == S_HOLD && !ramp_ff |-> drive_level == to_lvl_ff)
		else $error("step not held");
	fresh_start_a: assert property (@(posedge clock) disable iff (srst)
		state_ff == S_IDLE && play_start && seq_first && !seq_looped && snippet_index != 4'h0
		&& {4'h0, snippet_index} <= snippet_count |=> ##1 from_lvl_ff == 10'sh000)
		else $error("start not from zero");
	silence_go_a: assert property (@(posedge clock) disable iff (srst)
		state_ff == S_IDLE && play_start && snippet_index == 4'h0
		|=> ##1 point_strobe && point_out.point_amplitude == 5'sh00)
		else $error("silence point missing");
	done_end_a: assert property (@(posedge clock) disable iff (srst)
		snippet_done && !silence_ff |-> rd_addr_ff >= end_addr_ff)
		else $error("snippet ended early");
	tb_map_a: assert property (@(posedge clock) disable iff (srst)
		state_ff == S_IDLE && play_start && !short_step_table_select && timebase_code == 2'h0
		|=> tb_cycles_ff == 32'(TB0_CYCLES))
		else $error("timebase map wrong");
endmodule
`default_nettype wire

// >>> hwd_host_model.sv
// Host model that builds and preloads the waveform store image
`timescale 1ns/1ps
`default_nettype none
module hwd_host_model (
	// Clock
	input  wire logic       clock,
	// Store port
	output logic            mem_wr,
	output logic [6:0]      mem_addr,
	output logic [7:0]      mem_wdata,
	input  wire logic [7:0] mem_rdata
);
	logic [7:0] image [0:99];
	initial begin
		mem_wr = 1'b0;
		mem_addr = 7'h00;
		mem_wdata = 8'h00;
	end
	// Header, three snippets after it, two sequences after the snippets
	task automatic build();
		for (int a = 0; a < 100; a++) image[a] = 8'($urandom);
		image[0] = 8'h03;
		image[1] = 8'h02;
		image[2] = 8'h08;
		image[3] = 8'h0b;
		image[4] = 8'h0c;
		image[5] = 8'h0f;
		image[6] = 8'h14;
		image[7] = 8'haf;
		image[8] = 8'h48;
		image[9][7] = 1'b1;
		image[10] = {1'b0, 3'h7, image[9][3:0]};
		image[11] = {1'b0, 3'h7, image[9][3:0]};
		image[12] = 8'h78;
	endtask
	// One byte per cycle over the whole store
	task automatic load();
		for (int a = 0; a < 100; a++) begin
			@(posedge clock);
			#1;
			mem_wr = 1'b1;
			mem_addr = 7'(a);
			mem_wdata = image[a];
		end
		@(posedge clock);
		#1;
		mem_wr = 1'b0;
	endtask
	task automatic read(input logic [6:0] a, output logic [7:0] d);
		mem_addr = a;
		@(posedge clock);
		#1;
		d = mem_rdata;
	endtask
endmodule
`default_nettype wire

// >>> haptic_waveform_memory_decoder_tb.sv
// Self-checking testbench for the waveform memory decoder
`timescale 1ns/1ps
`default_nettype none
module haptic_waveform_memory_decoder_tb;
	logic                clock, srst, mem_wr, accel_en, short_step_table_select;
	logic                play_start, seq_first, seq_looped, seq_valid, busy;
	logic                point_strobe, snippet_done, bad_index;
	logic [6:0]          mem_addr, seq_start_addr, seq_end_addr;
	logic [7:0]          mem_wdata, mem_rdata, snippet_count, sequence_count, d;
	logic [3:0]          snippet_index, seq_index;
	logic [1:0]          timebase_code;
	logic signed [9:0]   drive_level;
	hwd_pkg::hwd_point_t point_out;
	hwd_pkg::hwd_point_t exp_q [$];
	int                  fails, n_compared, bcnt, scnt, last_amp;

	hwd_host_model i_host (.clock(clock), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	hwd_decoder #(.TB0_CYCLES(2), .TB1_CYCLES(3), .TB2_CYCLES(4), .TB3_CYCLES(5),
		.TBA0_CYCLES(1)) i_dut (.clock(clock), .srst(srst), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.accel_en(accel_en), .short_step_table_select(short_step_table_select),
		.play_start(play_start), .snippet_index(snippet_index),
		.timebase_code(timebase_code), .seq_first(seq_first), .seq_looped(seq_looped),
		.seq_index(seq_index), .seq_start_addr(seq_start_addr),
		.seq_end_addr(seq_end_addr), .seq_valid(seq_valid),
		.snippet_count(snippet_count), .sequence_count(sequence_count), .busy(busy),
		.point_strobe(point_strobe), .point_out(point_out),
		.snippet_done(snippet_done), .bad_index(bad_index), .drive_level(drive_level));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic hwd_pkg::hwd_point_t point_of(input logic [7:0] b, input logic acc);
		hwd_pkg::hwd_point_t p;
		p.ramp_flag = b[7];
		p.hold_tb = {1'b0, b[6:4]} + 4'h1;
		if (acc) p.point_amplitude = {1'b0, b[3:0]};
		else if (b[3:0] == 4'h8) p.point_amplitude = -5'sd7;
		else p.point_amplitude = {b[3], b[3:0]};
		return p;
	endfunction
	// Plays one snippet and compares every loaded point with the model
	task automatic play(input int idx, input logic first, input logic looped);
		int s, n, t0, span, tbl, la;
		hwd_pkg::hwd_point_t e;
		s = (idx == 1) ? 7 : int'(i_host.image[idx]) + 1;
		// Bench timebases: normal table 2 to 5 cycles, alternate table one cycle shorter
		tbl = idx + (short_step_table_select ? 1 : 2);
		la = (first && !looped) ? 0 : last_amp;
		t0 = 0;
		exp_q.delete();
		if (idx == 0) exp_q.push_back('{1'b0, 4'h2, 5'sd0});
		else for (int a = s; a <= int'(i_host.image[idx+1]); a++)
			exp_q.push_back(point_of(i_host.image[a], accel_en));
		n = exp_q.size();
		span = n - 1;
		foreach (exp_q[i]) span += int'(exp_q[i].hold_tb) * tbl;
		snippet_index = 4'(idx);
		timebase_code = 2'(idx);
		seq_first = first;
		seq_looped = looped;
		play_start = 1'b1;
		@(posedge clock);
		#1;
		for (int c = 0; c < 3000; c++) begin
			if (c == 0) check(busy, 1'b1);
			if (point_strobe === 1'b1 && exp_q.size() == 0) check(1, 0);
			else if (point_strobe === 1'b1) begin
				if (exp_q.size() == n) t0 = c;
				if (exp_q.size() == n && exp_q[0].ramp_flag)
					check(16'(drive_level), 16'(la));
				e = exp_q.pop_front();
				check(point_out, e);
				last_amp = int'($signed(e.point_amplitude));
			end
			if (snippet_done === 1'b1) begin
				check(16'(c - t0), 16'(span));
				break;
			end
			play_start = (c == 3);
			@(posedge clock);
			#1;
		end
		check(snippet_done, 1'b1);
		check(busy, 1'b0);
		play_start = 1'b0;
		check(exp_q.size(), 0);
		@(posedge clock);
		#1;
	endtask

	initial begin
		srst = 1'b1;
		accel_en = 1'b0;
		short_step_table_select = 1'b0;
		play_start = 1'b0;
		snippet_index = 4'h0;
		timebase_code = 2'h0;
		seq_first = 1'b0;
		seq_looped = 1'b0;
		seq_index = 4'h0;
		fails = 0;
		n_compared = 0;
		last_amp = 0;
		void'($urandom(38));
		i_host.build();
		repeat (4) @(posedge clock);
		#1;
		srst = 1'b0;
		i_host.load();
		i_host.read(7'h07, d);
		check(d, 8'haf);
		i_host.read(7'h64, d);
		check(d, 8'h00);
		check(snippet_count, 8'h03);
		check(sequence_count, 8'h02);
		for (int q = 0; q < 3; q++) begin
			seq_index = 4'(q);
			@(posedge clock);
			#1;
			check(seq_valid, q < 2);
			if (q < 2) check(seq_start_addr, i_host.image[4+q] + 8'h01);
			if (q < 2) check(seq_end_addr, i_host.image[5+q]);
		end
		for (int m = 0; m < 2; m++) begin
			accel_en = m[0];
			short_step_table_select = m[0];
			for (int k = 0; k < 4; k++)
				play((k == 0) ? 3 : (k == 3) ? 0 : k, k == 1, m == 1 && k == 2);
		end
		snippet_index = 4'h4;
		play_start = 1'b1;
		@(posedge clock);
		#1;
		play_start = 1'b0;
		bcnt = 0;
		scnt = 0;
		for (int c = 0; c < 4; c++) begin
			bcnt += int'(bad_index === 1'b1);
			scnt += int'(point_strobe === 1'b1);
			@(posedge clock);
			#1;
		end
		check(bcnt, 1);
		check(scnt, 0);
		report_and_stop();
	end
	initial begin
		#300000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
